// file: logic/spim_top.sv
// Master-only serial port with three selects, behind a 16-bit register port.
// Assumes one word access per cycle and a slave that honours the chosen mode.
`timescale 1ns/100ps
`default_nettype none

// Function
// RL1: The port is master only and drives clock and selects itself.
// RL2: Character length is programmable from one to thirty-two bits.
// RL3: Three select outputs exist and one is active per transfer.
// RL4: A frame holds one to 4096 characters under a single select assertion.
// RL5: A per-character interrupt pulse is raised only when enabled.
// RL6: Select to first data bit delay is programmable to zero to three serial clocks.
// RL7: Each select output has a software-chosen active level.
// RL8: The serial clock comes from a divider and is never under four system clocks.
// RL9: Polarity and phase settings form modes zero to three.
// RL10: Modes zero and three launch on falling and capture on rising edges.
// RL11: Modes one and two launch on rising and capture on falling edges.
// RL12: Select leads the first edge by one period plus delay and trails the last by half a period.
// RL13: Loopback feeds transmitted bits back into the receive path.
// RL14: No memory access requests exist; data moves through register access only.
// RL15: Characters shift most significant bit first both ways.
// RL16: A character sits across two data words and busy holds while shifting.
module spim_top (
  input  wire logic        mclk_i,
  input  wire logic        resetn_i,
  input  wire logic [15:0] addr_i,
  input  wire logic [15:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic      [15:0] rdata_o,
  output logic             irq_o,
  output logic             sclk_o,
  output logic             tx_o,
  input  wire logic        rx_i,
  output logic      [2:0]  cs_o
);
  import spim_pkg::*;

  // ------------------------------------------------------------
  // Registers and state
  // ------------------------------------------------------------
  logic [15:0]  clk_div;
  logic [15:0]  clk_ctrl;
  logic [15:0]  slave_lo;
  logic [15:0]  slave_hi;
  logic [15:0]  cmd_lo;
  logic [15:0]  cmd_hi;
  logic [15:0]  data_lo;
  logic [15:0]  data_hi;
  logic         char_flag;
  logic         frame_flag;
  spim_state_t  state;
  logic [5:0]   cnt;
  logic [11:0]  char_idx;
  logic [31:0]  tx_sh;
  logic [31:0]  rx_sh;
  logic         cur_cpol;
  logic         cur_cpha;
  logic [1:0]   cur_sel;
  logic [4:0]   cur_len;
  logic         char_done;
  logic         frame_done;
  logic         rx_sync;

  // ------------------------------------------------------------
  // Decode
  // ------------------------------------------------------------
  logic [23:0]  slave_all;
  logic [7:0]   slv_cfg;
  logic [2:0]   cs_pol;
  logic [2:0]   cs_idle;
  logic [2:0]   cs_act;
  logic [1:0]   req_sel;
  logic [4:0]   req_len;
  logic [1:0]   req_dly;
  logic         start_req;
  logic         start_ok;
  logic         shifting;
  logic [5:0]   last_edge;
  logic [5:0]   lead_ticks;
  logic         leading;
  logic         capture;
  logic         rx_bit;
  logic [31:0]  tx_word;
  logic [31:0]  tx_aligned;
  logic         tick;

  assign slave_all = {slave_hi[7:0], slave_lo};
  assign req_sel   = wdata_i[CMD_SEL_MSB:CMD_SEL_LSB];
  assign req_len   = wdata_i[CMD_LEN_MSB:CMD_LEN_LSB];
  assign slv_cfg   = (req_sel == 2'h2) ? slave_all[23:16] :
                     (req_sel == 2'h1) ? slave_all[15:8] : slave_all[7:0];
  assign req_dly   = slv_cfg[SLV_DLY_MSB:SLV_DLY_LSB];

  // Per-select active level
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_cs
      assign cs_pol[gi]  = slave_all[gi*SLV_FIELD_W + SLV_CSPOL_BIT]; // RL7
      assign cs_idle[gi] = ~cs_pol[gi];
      assign cs_act[gi]  = (cur_sel == 2'(gi)) ? cs_pol[gi] : ~cs_pol[gi]; // RL3
    end
  endgenerate

  // Start only from idle or between characters of the same frame
  assign start_req  = wr_i && (addr_i == ADDR_CMD_HI) && wdata_i[CMD_START_BIT];
  assign start_ok   = start_req && clk_ctrl[CTRL_EN_BIT] && (req_sel != NO_SLAVE_SEL)
                      && ((state == SPIM_IDLE) || (state == SPIM_HOLD && req_sel == cur_sel));
  assign shifting   = (state == SPIM_LEAD) || (state == SPIM_SHIFT) || (state == SPIM_TRAIL);
  assign last_edge  = {cur_len, 1'b1}; // RL2
  assign lead_ticks = LEAD_BASE_TICKS + {3'h0, req_dly, 1'b0};
  assign leading    = ~cnt[0];
  assign capture    = leading ^ cur_cpha; // RL9
  assign rx_bit     = clk_ctrl[CTRL_LOOP_BIT] ? tx_o : rx_sync; // RL13
  assign tx_word    = {data_hi, data_lo}; // RL16
  assign tx_aligned = tx_word << (5'h1F - req_len); // RL15

  // ------------------------------------------------------------
  // Divider and receive pin synchroniser
  // ------------------------------------------------------------
  spim_tick_if tk ();

  logic [5:0] lead_cnt_lim;
  logic [1:0] lead_dly;

  assign tk.run      = (state != SPIM_IDLE);
  assign tk.half_div = clk_div; // RL8
  assign tick        = tk.tick;

  spim_clkgen u_clkgen (
    .mclk_i   (mclk_i),
    .resetn_i (resetn_i),
    .tk       (tk)
  );

  spim_sync #(
    .WIDTH (1)
  ) u_rx_sync (
    .mclk_i   (mclk_i),
    .resetn_i (resetn_i),
    .async_i  (rx_i),
    .sync_o   (rx_sync)
  );

  // ------------------------------------------------------------
  // Configuration registers
  // ------------------------------------------------------------
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      clk_div  <= RST_CLK_DIV;
      clk_ctrl <= RST_WORD;
      slave_lo <= RST_WORD;
      slave_hi <= RST_WORD;
      cmd_lo   <= RST_WORD;
      cmd_hi   <= RST_WORD;
    end else if (wr_i) begin
      // Timing setup is frozen mid-frame to keep edges regular
      if (addr_i == ADDR_CLK_DIV && state == SPIM_IDLE) begin
        clk_div <= wdata_i;
      end
      if (addr_i == ADDR_CLK_CTRL) begin
        clk_ctrl <= wdata_i;
      end
      if (addr_i == ADDR_SLAVE_LO && state == SPIM_IDLE) begin
        slave_lo <= wdata_i;
      end
      if (addr_i == ADDR_SLAVE_HI && state == SPIM_IDLE) begin
        slave_hi <= wdata_i;
      end
      if (addr_i == ADDR_CMD_LO && state == SPIM_IDLE) begin
        cmd_lo <= wdata_i;
      end
      if (addr_i == ADDR_CMD_HI && !shifting) begin
        cmd_hi <= {wdata_i[15:1], 1'b0};
      end
    end
  end

  // ------------------------------------------------------------
  // Data words
  // ------------------------------------------------------------
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      data_lo <= RST_WORD;
      data_hi <= RST_WORD;
    end else if (char_done) begin
      data_lo <= rx_sh[15:0]; // RL16
      data_hi <= rx_sh[31:16];
    end else if (wr_i && !shifting) begin
      // Processor writes every outgoing character; each finished character also loads the received bits here
      if (addr_i == ADDR_DATA_LO) begin
        data_lo <= wdata_i; // RL14
      end
      if (addr_i == ADDR_DATA_HI) begin
        data_hi <= wdata_i;
      end
    end
  end

  // ------------------------------------------------------------
  // Transfer sequencer
  // ------------------------------------------------------------
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state      <= SPIM_IDLE;
      cnt        <= 6'h00;
      char_idx   <= 12'h000;
      tx_sh      <= 32'h0000_0000;
      rx_sh      <= 32'h0000_0000;
      cur_cpol   <= 1'b0;
      cur_cpha   <= 1'b0;
      cur_sel    <= 2'h0;
      cur_len    <= 5'h00;
      lead_cnt_lim <= 6'h00;
      lead_dly   <= 2'h0;
      sclk_o     <= 1'b0;
      tx_o       <= 1'b0;
      cs_o       <= RST_CS_OUT;
      char_done  <= 1'b0;
      frame_done <= 1'b0;
    end else begin
      char_done  <= 1'b0;
      frame_done <= 1'b0;
      unique case (state)
        SPIM_IDLE: begin
          cs_o   <= cs_idle; // RL7
          sclk_o <= slv_cfg[SLV_CPOL_BIT];
          if (start_ok) begin
            cur_cpol     <= slv_cfg[SLV_CPOL_BIT];
            cur_cpha     <= slv_cfg[SLV_CPHA_BIT];
            cur_sel      <= req_sel;
            cur_len      <= req_len;
            lead_dly     <= req_dly; // RL6
            lead_cnt_lim <= lead_ticks - 6'h01;
            char_idx     <= 12'h000;
            rx_sh        <= 32'h0000_0000;
            cnt          <= 6'h00;
            sclk_o       <= slv_cfg[SLV_CPOL_BIT]; // RL1
            cs_o         <= cs_idle ^ (3'h1 << req_sel); // RL3
            if (!slv_cfg[SLV_CPHA_BIT]) begin
              tx_o  <= tx_aligned[31];
              tx_sh <= tx_aligned << 1;
            end else begin
              tx_sh <= tx_aligned;
            end
            state <= SPIM_LEAD;
          end
        end
        SPIM_LEAD: begin
          cs_o <= cs_act;
          if (tick) begin
            // One full period plus the programmed delay before the first edge
            if (cnt == lead_cnt_lim) begin // RL12
              cnt   <= 6'h00;
              state <= SPIM_SHIFT;
            end else begin
              cnt <= cnt + 6'h01;
            end
          end
        end
        SPIM_SHIFT: begin
          cs_o <= cs_act;
          if (tick) begin
            sclk_o <= ~sclk_o;
            if (capture) begin
              rx_sh <= {rx_sh[30:0], rx_bit}; // RL10 RL11 RL15
            end else if (cur_cpha || cnt != last_edge) begin
              tx_o  <= tx_sh[31]; // RL10 RL11
              tx_sh <= tx_sh << 1;
            end
            if (cnt == last_edge) begin
              cnt       <= 6'h00;
              char_done <= 1'b1;
              if (char_idx == cmd_lo[CMD_FRAME_MSB:0]) begin // RL4
                state <= SPIM_TRAIL;
              end else begin
                char_idx <= char_idx + 12'h001;
                state    <= SPIM_HOLD;
              end
            end else begin
              cnt <= cnt + 6'h01;
            end
          end
        end
        SPIM_HOLD: begin
          // Select stays asserted between characters of one frame
          cs_o   <= cs_act; // RL4
          sclk_o <= cur_cpol;
          if (start_ok) begin
            cur_len <= req_len;
            rx_sh   <= 32'h0000_0000;
            cnt     <= 6'h00;
            if (!cur_cpha) begin
              tx_o  <= tx_aligned[31];
              tx_sh <= tx_aligned << 1;
            end else begin
              tx_sh <= tx_aligned;
            end
            state <= SPIM_SHIFT;
          end
        end
        SPIM_TRAIL: begin
          cs_o <= cs_act;
          if (tick) begin
            // Half a period after the last edge before release
            cs_o       <= cs_idle; // RL12
            frame_done <= 1'b1;
            state      <= SPIM_IDLE;
          end
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // Status flags and interrupt
  // ------------------------------------------------------------
  logic stat_rd;

  assign stat_rd = rd_i && (addr_i == ADDR_STAT_LO);

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      char_flag  <= 1'b0;
      frame_flag <= 1'b0;
    end else begin
      // Set beats a clearing read in the same cycle
      if (char_done) begin
        char_flag <= 1'b1;
      end else if (stat_rd) begin
        char_flag <= 1'b0;
      end
      if (frame_done) begin
        frame_flag <= 1'b1;
      end else if (stat_rd) begin
        frame_flag <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= char_done && cmd_lo[CMD_IRQ_BIT]; // RL5
    end
  end

  // ------------------------------------------------------------
  // Read port
  // ------------------------------------------------------------
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rdata_o <= RST_WORD;
    end else if (rd_i) begin
      case (addr_i)
        ADDR_CLK_DIV:  rdata_o <= clk_div;
        ADDR_CLK_CTRL: rdata_o <= clk_ctrl;
        ADDR_SLAVE_LO: rdata_o <= slave_lo;
        ADDR_SLAVE_HI: rdata_o <= slave_hi;
        ADDR_CMD_LO:   rdata_o <= cmd_lo;
        ADDR_CMD_HI:   rdata_o <= cmd_hi;
        ADDR_STAT_LO:  rdata_o <= {13'h0000, frame_flag, char_flag, shifting}; // RL16
        ADDR_STAT_HI:  rdata_o <= {4'h0, char_idx};
        ADDR_DATA_LO:  rdata_o <= data_lo;
        ADDR_DATA_HI:  rdata_o <= data_hi;
        default:       rdata_o <= RST_WORD;
      endcase
    end
  end

endmodule
`default_nettype wire

// file: logic/spim_pkg.sv
// Constants, register map and state codes for the three-select serial master.
// Assumes a 16-bit word-addressed processor register port on one clock.
package spim_pkg;

  // ------------------------------------------------------------
  // Register word addresses
  // ------------------------------------------------------------
  localparam logic [15:0] ADDR_CLK_DIV    = 16'h3000;
  localparam logic [15:0] ADDR_CLK_CTRL   = 16'h3001;
  localparam logic [15:0] ADDR_SLAVE_LO   = 16'h3002;
  localparam logic [15:0] ADDR_SLAVE_HI   = 16'h3003;
  localparam logic [15:0] ADDR_CMD_LO     = 16'h3004;
  localparam logic [15:0] ADDR_CMD_HI     = 16'h3005;
  localparam logic [15:0] ADDR_STAT_LO    = 16'h3006;
  localparam logic [15:0] ADDR_STAT_HI    = 16'h3007;
  localparam logic [15:0] ADDR_DATA_LO    = 16'h3008;
  localparam logic [15:0] ADDR_DATA_HI    = 16'h3009;

  // ------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------
  localparam logic [15:0] RST_WORD        = 16'h0000;
  localparam logic [15:0] RST_CLK_DIV     = 16'h0003;
  localparam logic [2:0]  RST_CS_OUT      = 3'h7;

  // ------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------
  localparam int CTRL_LOOP_BIT   = 0;
  localparam int CTRL_EN_BIT     = 15;
  localparam int SLV_CPOL_BIT    = 0;
  localparam int SLV_CPHA_BIT    = 1;
  localparam int SLV_CSPOL_BIT   = 2;
  localparam int SLV_DLY_LSB     = 3;
  localparam int SLV_DLY_MSB     = 4;
  localparam int SLV_FIELD_W     = 8;
  localparam int CMD_FRAME_MSB   = 11;
  localparam int CMD_IRQ_BIT     = 14;
  localparam int CMD_START_BIT   = 0;
  localparam int CMD_LEN_LSB     = 3;
  localparam int CMD_LEN_MSB     = 7;
  localparam int CMD_SEL_LSB     = 12;
  localparam int CMD_SEL_MSB     = 13;
  localparam int STAT_BUSY_BIT   = 0;
  localparam int STAT_CHAR_BIT   = 1;
  localparam int STAT_FRAME_BIT  = 2;

  // ------------------------------------------------------------
  // Timing counts, unused select code and state codes
  // ------------------------------------------------------------
  localparam logic [15:0] MIN_HALF_CYCLES = 16'h0003;
  localparam logic [5:0]  LEAD_BASE_TICKS = 6'h01;
  localparam logic [1:0]  NO_SLAVE_SEL    = 2'h3;

  typedef enum logic [4:0] {
    SPIM_IDLE  = 5'h01,
    SPIM_LEAD  = 5'h02,
    SPIM_SHIFT = 5'h04,
    SPIM_HOLD  = 5'h08,
    SPIM_TRAIL = 5'h10
  } spim_state_t;

endpackage

// file: logic/spim_tick_if.sv
// Half-period tick link between the controller and its bit-rate divider.
// Assumes both ends share mclk_i.
`timescale 1ns/100ps
`default_nettype none
interface spim_tick_if;
  logic        run;
  logic [15:0] half_div;
  logic        tick;
  modport ctrl (output run, output half_div, input tick);
  modport gen  (input run, input half_div, output tick);
endinterface
`default_nettype wire

// file: logic/spim_clkgen.sv
// Bit-rate divider: one tick per serial half period.
// Assumes half_div stays steady while run is high.
`timescale 1ns/100ps
`default_nettype none
module spim_clkgen (
  input  wire logic  mclk_i,
  input  wire logic  resetn_i,
  spim_tick_if.gen   tk
);
  import spim_pkg::*;

  logic [15:0] cnt;
  logic [15:0] limit;

  // Half period floored at three clocks so the two-flop rx path settles
  assign limit = (tk.half_div < MIN_HALF_CYCLES - 16'h0001) ? MIN_HALF_CYCLES : tk.half_div + 16'h0001; // RL8

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cnt     <= 16'h0000;
      tk.tick <= 1'b0;
    end else if (!tk.run) begin
      cnt     <= 16'h0000;
      tk.tick <= 1'b0;
    end else if (cnt >= limit - 16'h0001) begin
      cnt     <= 16'h0000;
      tk.tick <= 1'b1;
    end else begin
      cnt     <= cnt + 16'h0001;
      tk.tick <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// file: logic/spim_sync.sv
// Two-stage synchroniser for pin inputs.
// Assumes inputs are asynchronous to mclk_i.
`timescale 1ns/100ps
`default_nettype none
module spim_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             mclk_i,
  input  wire logic             resetn_i,
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] stage1;

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      stage1 <= '0;
      sync_o <= '0;
    end else begin
      stage1 <= async_i;
      sync_o <= stage1;
    end
  end
endmodule
`default_nettype wire

// file: dv/spim_top_props.sv
// Checker for the three-select serial master, on its top ports only.
// Assumes slave setup is written only while no frame runs.
`timescale 1ns/100ps
`default_nettype none
module spim_top_props
  import spim_pkg::*;
(
  input wire logic        mclk_i,
  input wire logic        resetn_i,
  input wire logic [15:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic        wr_i,
  input wire logic        rd_i,
  input wire logic [15:0] rdata_o,
  input wire logic        irq_o,
  input wire logic        sclk_o,
  input wire logic        tx_o,
  input wire logic [2:0]  cs_o
);
  // ------------------------------------------------------------
  // Shadow of the setup
  // ------------------------------------------------------------
  logic [7:0] cfg0, cfg1, cfg2, scfg;
  logic [1:0] sel;
  logic       irq_en;
  logic [2:0] quiet;
  logic [2:0] act;
  logic       any_act;

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!resetn_i);

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      {cfg2, cfg1, cfg0} <= 24'h000000;
    end else if (wr_i && addr_i == ADDR_SLAVE_LO) begin
      {cfg1, cfg0} <= wdata_i;
    end else if (wr_i && addr_i == ADDR_SLAVE_HI) begin
      cfg2 <= wdata_i[7:0];
    end
  end

  // Select levels settle a few cycles after a polarity write
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      quiet <= 3'h0;
    end else if (wr_i && (addr_i == ADDR_SLAVE_LO || addr_i == ADDR_SLAVE_HI)) begin
      quiet <= 3'h0;
    end else if (quiet != 3'h4) begin
      quiet <= quiet + 3'h1;
    end
  end

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      {sel, irq_en} <= 3'h0;
    end else if (wr_i && addr_i == ADDR_CMD_HI && wdata_i[CMD_START_BIT]) begin
      sel <= wdata_i[CMD_SEL_MSB:CMD_SEL_LSB];
    end else if (wr_i && addr_i == ADDR_CMD_LO) begin
      irq_en <= wdata_i[CMD_IRQ_BIT];
    end
  end

  assign act = (quiet == 3'h4) ? (cs_o ~^ {cfg2[SLV_CSPOL_BIT], cfg1[SLV_CSPOL_BIT], cfg0[SLV_CSPOL_BIT]}) : 3'h0;
  assign any_act = |act;
  assign scfg = (sel == 2'h0) ? cfg0 : (sel == 2'h1) ? cfg1 : cfg2;

  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  a_one_select: assert property ($onehot0(act))
    else $error("more than one select active");
  a_sclk_half: assert property ($changed(sclk_o) |=> $stable(sclk_o))
    else $error("serial clock half period below two cycles");
  a_select_lead: assert property ($rose(any_act) |=> $stable(sclk_o) [*3])
    else $error("serial clock moved too soon after select");
  a_select_trail: assert property ($fell(any_act) |-> sclk_o == $past(sclk_o) && sclk_o == $past(sclk_o, 2))
    else $error("select released too soon after last edge");
  a_select_fixed: assert property (any_act && $past(any_act) |-> act == $past(act))
    else $error("select changed inside a frame");
  a_irq_pulse: assert property (irq_o |-> irq_en ##1 !irq_o)
    else $error("character interrupt wrong");
  a_tx_launch: assert property (any_act && $changed(sclk_o) && (sclk_o ^ scfg[SLV_CPOL_BIT] ^ scfg[SLV_CPHA_BIT])
                                |-> $stable(tx_o))
    else $error("data out moved on a capture edge");
  a_idle_busy: assert property (rd_i && addr_i == ADDR_STAT_LO && !any_act && !$past(wr_i)
                                |=> !rdata_o[STAT_BUSY_BIT])
    else $error("busy seen while idle");
endmodule

bind spim_top spim_top_props u_props (
  .mclk_i(mclk_i), .resetn_i(resetn_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
  .rdata_o(rdata_o), .irq_o(irq_o), .sclk_o(sclk_o), .tx_o(tx_o), .cs_o(cs_o)
);
`default_nettype wire

// file: dv/spim_slave_model.sv
// Behavioural slave on the far side of the serial link.
// Assumes the bench gives it its mode, select state and reply word.
`timescale 1ns/100ps
`default_nettype none
module spim_slave_model (
  input  wire logic        mclk_i,
  input  wire logic        sel_i,
  input  wire logic        cpol_i,
  input  wire logic        cpha_i,
  input  wire logic        sclk_i,
  input  wire logic        tx_i,
  input  wire logic [31:0] resp_i,
  output logic             rx_o,
  output logic      [31:0] cap_o
);
  int n;

  initial begin
    n = 0;
    rx_o = 1'b0;
    cap_o = 32'h0;
  end

  // Reply always starts at bit 31, whatever the length
  always @(posedge sel_i) begin
    n = 0;
    cap_o = 32'h0;
    if (!cpha_i) rx_o <= #1 resp_i[31];
  end

  always @(sclk_i) begin
    if (sel_i && (sclk_i ^ cpol_i ^ cpha_i)) begin
      cap_o = {cap_o[30:0], tx_i};
    end else if (sel_i) begin
      n = n + 1;
      rx_o <= #1 resp_i[31 - ((cpha_i ? n - 1 : n) & 31)];
    end
  end

  // Deselected line toggles so no stale bit can pass for data
  always @(posedge mclk_i) begin
    if (!sel_i) rx_o <= ~rx_o;
  end
endmodule
`default_nettype wire

// file: dv/spim_tb_top.sv
// Self-checking bench for the three-select serial master.
// Assumes the slave model on the link and the bound checker.
`timescale 1ns/100ps
`default_nettype none
module spim_tb_top;
  import spim_pkg::*;
  logic        mclk, resetn, wr, rd, irq, sclk, tx, rx, sel;
  logic [15:0] addr, wdata, rdata;
  logic [2:0]  cs;
  logic [1:0]  cur;
  logic [31:0] resp, cap;
  logic [7:0]  slv [3];
  int          bad_count = 0, checks_done = 0, irq_cnt = 0, cyc = 0, hp = 4;

  spim_top uut (.mclk_i(mclk), .resetn_i(resetn), .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
    .rdata_o(rdata), .irq_o(irq), .sclk_o(sclk), .tx_o(tx), .rx_i(rx), .cs_o(cs));
  spim_slave_model u_slave (.mclk_i(mclk), .sel_i(sel), .cpol_i(slv[cur][SLV_CPOL_BIT]),
    .cpha_i(slv[cur][SLV_CPHA_BIT]), .sclk_i(sclk), .tx_i(tx), .resp_i(resp), .rx_o(rx), .cap_o(cap));
  assign sel = cs[cur] ~^ slv[cur][SLV_CSPOL_BIT];

  // ------------------------------------------------------------
  // Bus cycles and comparison
  // ------------------------------------------------------------
  task automatic wreg(input logic [15:0] a, input logic [15:0] d);
    @(posedge mclk); #10;
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(posedge mclk); #10;
    wr = 1'b0;
  endtask

  task automatic rreg(input logic [15:0] a, output logic [15:0] d);
    @(posedge mclk); #10;
    addr = a;
    rd = 1'b1;
    @(posedge mclk); #10;
    rd = 1'b0;
    @(posedge mclk); #10;
    d = rdata;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cfg(input int s, input logic [7:0] v);
    slv[s] = v;
    wreg(ADDR_SLAVE_LO, {slv[1], slv[0]});
    wreg(ADDR_SLAVE_HI, {8'h00, slv[2]});
  endtask

  // One-character frame, judged on both lines
  task automatic xfer(input logic [1:0] s, input int len, input logic [31:0] d, input logic [31:0] r, input logic ie);
    logic [15:0] lo, hi;
    logic [31:0] m;
    int          n, i0;
    cur = s;
    resp = r;
    m = 32'hFFFF_FFFF >> (32 - len);
    wreg(ADDR_DATA_LO, d[15:0]);
    wreg(ADDR_DATA_HI, d[31:16]);
    wreg(ADDR_CMD_LO, {1'b0, ie, 14'h0000});
    i0 = irq_cnt;
    wreg(ADDR_CMD_HI, {2'b00, s, 4'h0, 5'(len - 1), 3'b001});
    n = 0;
    while (sclk === slv[s][SLV_CPOL_BIT] && n < 300) begin
      @(posedge mclk); #10;
      n++;
    end
    // One extra clock for the registered divider tick
    chk(n, (2 + 2 * slv[s][4:3]) * hp + 1);
    while (sel === 1'b1 && n < 3000) begin
      @(posedge mclk); #10;
      n++;
    end
    chk(sel, 1'b0);
    chk(sclk, slv[s][SLV_CPOL_BIT]);
    rreg(ADDR_DATA_LO, lo);
    rreg(ADDR_DATA_HI, hi);
    chk({hi, lo}, r >> (32 - len));
    chk(cap & m, d & m);
    chk(irq_cnt - i0, ie);
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_reset;
    logic [15:0] v;
    chk(cs, RST_CS_OUT);
    rreg(ADDR_CLK_DIV, v);
    chk(v, RST_CLK_DIV);
    wreg(ADDR_STAT_LO, 16'hFFFF);
    rreg(ADDR_STAT_LO, v);
    chk(v, 16'h0000);
    rreg(16'h300A, v);
    chk(v, 16'h0000);
    wreg(ADDR_CMD_HI, 16'h0001);
    repeat (20) @(posedge mclk);
    #10;
    chk(cs, RST_CS_OUT);
    wreg(ADDR_CLK_CTRL, 16'h8000);
    $display("reset test done");
  endtask

  // Shortest and longest characters, second and third select
  task automatic t_lengths;
    xfer(2'h1, 1, 32'h0000_0001, 32'h8000_0000, 1'b0);
    cfg(0, 8'h01);
    cfg(2, 8'h07);
    xfer(2'h2, 32, 32'h8E3A_C56B, 32'hC3A5_1E69, 1'b1);
    chk(cs, 3'h3);
    $display("length test done");
  endtask

  // Mode m also sets a delay of m serial clocks
  task automatic t_modes;
    logic [1:0] mm;
    for (int m = 0; m < 4; m++) begin
      mm = 2'(m);
      cfg(0, {3'b000, mm, 1'b0, mm[0], mm[1]});
      xfer(2'h0, 8, 32'h0000_00A5, 32'h5A3C_0000, 1'b1);
    end
    $display("mode test done");
  endtask

  task automatic t_frame;
    logic [15:0] v;
    int          n, i0;
    cfg(0, 8'h00);
    cur = 2'h0;
    resp = 32'h3C96_0000;
    // Flush sticky flags left by earlier frames
    rreg(ADDR_STAT_LO, v);
    i0 = irq_cnt;
    wreg(ADDR_DATA_LO, 16'h0055);
    wreg(ADDR_CMD_LO, 16'h4001);
    wreg(ADDR_CMD_HI, 16'h0039);
    v = 16'h0000;
    n = 0;
    while (v[STAT_CHAR_BIT] !== 1'b1 && n < 100) begin
      rreg(ADDR_STAT_LO, v);
      n++;
    end
    chk(sel, 1'b1);
    wreg(ADDR_DATA_LO, 16'h00C3);
    wreg(ADDR_CMD_HI, 16'h0039);
    while (sel === 1'b1 && n < 1000) begin
      @(posedge mclk); #10;
      n++;
    end
    rreg(ADDR_STAT_LO, v);
    chk(v[2:0], 3'b110);
    rreg(ADDR_DATA_LO, v);
    chk(v, 16'h0096);
    chk(cap[7:0], 8'hC3);
    chk(irq_cnt - i0, 2);
    $display("frame test done");
  endtask

  // Loopback at the fastest divider setting
  task automatic t_loop;
    wreg(ADDR_CLK_CTRL, 16'h8001);
    wreg(ADDR_CLK_DIV, 16'h0000);
    hp = 3;
    cfg(0, 8'h02);
    xfer(2'h0, 16, 32'h0000_B2C4, 32'hB2C4_0000, 1'b1);
    $display("loopback test done");
  endtask

  task automatic stop_test;
    $display("checks=%0d mismatches=%0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  // Hang guard, far above the roughly one thousand cycles the run needs
  always @(posedge mclk) begin
    cyc++;
    if (irq === 1'b1) irq_cnt++;
    if (cyc == 30000) begin
      bad_count++;
      stop_test;
    end
  end

  initial begin
    resetn = 1'b0;
    {addr, wdata, wr, rd} = 34'h0;
    cur = 2'h0;
    resp = 32'h0;
    slv = '{default: 8'h00};
    repeat (6) @(posedge mclk);
    #10;
    resetn = 1'b1;
    t_reset;
    t_lengths;
    t_modes;
    t_frame;
    t_loop;
    stop_test;
  end
endmodule
`default_nettype wire
